// File: rtl/atx_power_reset.sv
// host power and reset sequencer with watchdog, registers on APB
// assumes keys and sense inputs already synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module atx_power_reset
    import atx_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // apb slave
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0] pstrb,
    output logic [31:0]     prdata,
    output logic            pready,
    output logic            pslverr,
    // keypad
    input  wire logic       confirm_key,
    input  wire logic       cancel_key,
    // host power sense
    input  wire logic       sense_5v,
    input  wire logic       sense_gpio,
    // host reset and power control lines
    input  wire logic       rst_line_in,
    output line_drv_t       rst_drv,
    input  wire logic       pwr_line_in,
    output line_drv_t       pwr_drv,
    // display
    output logic            display_blank,
    output logic            backlight_off
);

    logic        tick;
    cfg_t        cfg_r;
    seq_state_t  state_r, state_nxt;
    pulse_src_t  src_r, src_nxt;
    logic [8:0]  pulse_cnt_r, pulse_cnt_nxt;
    logic [8:0]  conf_cnt_r;
    logic [8:0]  canc_cnt_r;
    logic [5:0]  sec_cnt_r;
    logic [7:0]  wd_cnt_r;
    logic        wd_armed_r;
    logic        wd_pend_r;
    logic        host_on_r;
    logic        rst_idle_r;
    logic        pwr_idle_r;
    logic [7:0]  ack_code_r;
    logic        ack_valid_r;

    tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick)
    );

    // sense selection and restart
    wire host_on;
    wire sense_rise;
    wire restart;
    wire locked;
    assign host_on    = cfg_r.sense_internal ? sense_5v : sense_gpio;
    assign sense_rise = host_on & ~host_on_r;
    assign restart    = sense_rise | ((state_r == ST_RESTART) & tick);
    assign locked     = (state_r == ST_RESTART);

    // apb decode
    wire sel_cfg  = (paddr == ADDR_CONFIG);
    wire sel_wd   = (paddr == ADDR_WDOG);
    wire sel_st   = (paddr == ADDR_STATE);
    wire sel_ack  = (paddr == ADDR_ACK);
    wire sel_rb   = (paddr == ADDR_RB0) | (paddr == ADDR_RB1) |
                    (paddr == ADDR_RB2) | (paddr == ADDR_RB3);
    wire addr_hit = sel_cfg | sel_wd | sel_st | sel_ack | sel_rb;
    wire wr_ro    = sel_st | sel_ack | sel_rb;
    wire req_err  = ~addr_hit |
                    (pwrite & (wr_ro | locked | ((sel_cfg | sel_wd) & ~pstrb[0])));
    wire setup_ph = psel & penable & ~pready;
    wire acc      = psel & penable & pready & ~pslverr;
    wire wr_cfg   = acc & pwrite & sel_cfg;
    wire wr_wd    = acc & pwrite & sel_wd;
    wire rd_ack   = acc & ~pwrite & sel_ack;
    wire rd_rb    = acc & ~pwrite & sel_rb;

    // readback bytes 7, 8 and 11
    wire [31:0] rb1_word = {cfg_r.mask, 24'h0};
    wire [31:0] rb2_word = {7'h0, cfg_r.sense_internal, 16'h0, wd_cnt_r};
    wire [31:0] cfg_word = {15'h0, cfg_r.sense_internal, cfg_r.pulse_len, cfg_r.mask};
    wire [31:0] wd_word  = {23'h0, wd_armed_r, wd_cnt_r};
    wire [31:0] st_word  = {24'h0, wd_pend_r, host_on, rst_drv.oe, pwr_drv.oe,
                            1'b0, state_r};
    wire [31:0] ack_word = {23'h0, ack_valid_r, ack_code_r};
    wire [31:0] rd_data  = sel_cfg ? cfg_word :
                           sel_wd  ? wd_word  :
                           sel_st  ? st_word  :
                           sel_ack ? ack_word :
                           (paddr == ADDR_RB1) ? rb1_word :
                           (paddr == ADDR_RB2) ? rb2_word : 32'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & req_err;
            prdata  <= (setup_ph & ~pwrite & ~req_err) ? rd_data : 32'h0;
        end
    end

    // configuration, one byte lane per parameter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_r <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r.mask <= pwdata[7:0];
            if (pstrb[1]) begin
                cfg_r.pulse_len <= pwdata[15:8];
            end
            if (pstrb[2]) begin
                cfg_r.sense_internal <= pwdata[16];
            end
        end
    end

    // acknowledge: a new acknowledge beats the read that clears it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_code_r  <= 8'h00;
            ack_valid_r <= 1'b0;
        end else if (restart) begin
            ack_code_r  <= 8'h00;
            ack_valid_r <= 1'b0;
        end else if (wr_cfg | wr_wd | rd_rb) begin
            ack_code_r  <= wr_cfg ? ACK_CONFIG : (wr_wd ? ACK_WDOG : ACK_READ);
            ack_valid_r <= 1'b1;
        end else if (rd_ack) begin
            ack_valid_r <= 1'b0;
        end
    end

    // key hold timers
    wire conf_long  = tick & confirm_key & (conf_cnt_r == HOLD_LONG_TICKS - 9'd1);
    wire conf_short = tick & confirm_key & (conf_cnt_r == HOLD_SHORT_TICKS - 9'd1);
    wire canc_long  = tick & cancel_key & (canc_cnt_r == HOLD_LONG_TICKS - 9'd1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conf_cnt_r <= 9'h0;
            canc_cnt_r <= 9'h0;
        end else begin
            if (~confirm_key | restart) begin
                conf_cnt_r <= 9'h0;
            end else if (tick & (conf_cnt_r != 9'h1ff)) begin
                conf_cnt_r <= conf_cnt_r + 9'h1;
            end
            if (~cancel_key | restart) begin
                canc_cnt_r <= 9'h0;
            end else if (tick & (canc_cnt_r != 9'h1ff)) begin
                canc_cnt_r <= canc_cnt_r + 9'h1;
            end
        end
    end

    // host watchdog, counts whole seconds of ticks
    wire sec_edge  = tick & (sec_cnt_r == WD_SECOND_TICKS - 6'd1);
    wire wd_take   = (state_r == ST_IDLE) & wd_pend_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wd_cnt_r   <= 8'h00;
            wd_armed_r <= 1'b0;
            wd_pend_r  <= 1'b0;
            sec_cnt_r  <= 6'h0;
        end else if (restart) begin
            wd_cnt_r   <= 8'h00;
            wd_armed_r <= 1'b0;
            wd_pend_r  <= 1'b0;
            sec_cnt_r  <= 6'h0;
        end else if (wr_wd) begin
            wd_cnt_r   <= pwdata[7:0];
            wd_armed_r <= (pwdata[7:0] != 8'h00);
            wd_pend_r  <= 1'b0;
            sec_cnt_r  <= 6'h0;
        end else begin
            sec_cnt_r <= sec_edge ? 6'h0 : (tick ? sec_cnt_r + 6'h1 : sec_cnt_r);
            if (wd_armed_r & sec_edge) begin
                wd_cnt_r <= wd_cnt_r - 8'h01;
                if (wd_cnt_r == 8'h01) begin
                    wd_armed_r <= 1'b0;
                    wd_pend_r  <= 1'b1;
                end
            end else if (wd_take) begin
                wd_pend_r <= 1'b0;
            end
        end
    end

    // pulse sequencer
    wire [8:0] pwr_len  = (cfg_r.pulse_len == 8'h00) ? PULSE_DEF_TICKS : {1'b0, cfg_r.pulse_len};
    wire       cnt_end  = tick & (pulse_cnt_r == 9'h1);

    always_comb begin
        state_nxt     = state_r;
        src_nxt       = src_r;
        pulse_cnt_nxt = tick ? pulse_cnt_r - 9'h1 : pulse_cnt_r;
        case (state_r)
            ST_IDLE: begin
                pulse_cnt_nxt = pulse_cnt_r;
                if (wd_pend_r) begin
                    state_nxt     = ST_RST_PULSE;
                    src_nxt       = SRC_WDOG;
                    pulse_cnt_nxt = PULSE_DEF_TICKS;
                end else if (cfg_r.mask[MASK_KEY_RST] & host_on & conf_long) begin
                    state_nxt     = ST_RST_PULSE;
                    src_nxt       = SRC_KEY_RST;
                    pulse_cnt_nxt = PULSE_DEF_TICKS;
                end else if (cfg_r.mask[MASK_KEY_PWRON] & ~host_on & conf_short) begin
                    state_nxt     = ST_PWR_PULSE;
                    src_nxt       = SRC_KEY_ON;
                    pulse_cnt_nxt = pwr_len;
                end else if (cfg_r.mask[MASK_KEY_PWROF] & host_on & canc_long) begin
                    state_nxt     = ST_PWR_PULSE;
                    src_nxt       = SRC_KEY_OFF;
                    pulse_cnt_nxt = pwr_len;
                end
            end
            ST_RST_PULSE: begin
                if (cnt_end) begin
                    state_nxt = (src_r == SRC_KEY_RST) ? ST_RESTART : ST_IDLE;
                end
            end
            ST_PWR_PULSE: begin
                if (cnt_end) begin
                    if (src_r == SRC_KEY_ON) begin
                        state_nxt = ST_RESTART;
                    end else if (cancel_key) begin
                        state_nxt     = ST_PWR_EXTEND;
                        pulse_cnt_nxt = EXTEND_TICKS;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_PWR_EXTEND: begin
                if (~cancel_key | cnt_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_RESTART: begin
                pulse_cnt_nxt = 9'h0;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (restart) begin
            state_nxt     = ST_IDLE;
            pulse_cnt_nxt = 9'h0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            src_r       <= SRC_KEY_RST;
            pulse_cnt_r <= 9'h0;
            host_on_r   <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            src_r       <= src_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            host_on_r   <= host_on;
        end
    end

    // line drive; idle level sampled only while released, so own drive never feeds back
    wire rst_drive = (state_nxt == ST_RST_PULSE);
    wire pwr_drive = (state_nxt == ST_PWR_PULSE) | (state_nxt == ST_PWR_EXTEND);
    wire rst_level = cfg_r.mask[MASK_AUTO_POL] ? ~rst_idle_r : cfg_r.mask[MASK_RST_INV];
    wire pwr_level = cfg_r.mask[MASK_AUTO_POL] ? ~pwr_idle_r : cfg_r.mask[MASK_PWR_INV];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rst_idle_r    <= 1'b1;
            pwr_idle_r    <= 1'b1;
            rst_drv       <= '{out: 1'b0, oe: 1'b0};
            pwr_drv       <= '{out: 1'b0, oe: 1'b0};
            display_blank <= 1'b0;
            backlight_off <= 1'b0;
        end else begin
            if (~rst_drv.oe) begin
                rst_idle_r <= rst_line_in;
            end
            if (~pwr_drv.oe) begin
                pwr_idle_r <= pwr_line_in;
            end
            rst_drv       <= '{out: rst_drive & rst_level, oe: rst_drive};
            pwr_drv       <= '{out: pwr_drive & pwr_level, oe: pwr_drive};
            display_blank <= cfg_r.mask[MASK_BLANK] & ~host_on;
            backlight_off <= cfg_r.mask[MASK_BLANK] & ~host_on;
        end
    end

endmodule

`default_nettype wire

// File: rtl/tick_gen.sv
// time base divider: one-cycle tick every CYCLES clocks
// assumes a free-running clock; the count restarts under reset only
`timescale 1ns/100ps
`default_nettype none

module tick_gen #(
    parameter int CYCLES = 6250000
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // tick out
    output logic      tick
);

    logic [31:0] cnt_r;
    logic        last;

    assign last = (cnt_r == 32'(CYCLES - 1));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= last ? 32'h0 : cnt_r + 32'h1;
            tick  <= last;
        end
    end

endmodule

`default_nettype wire

// File: shared/atx_pkg.sv
// constants, field layouts and carrier types of the host power and reset sequencer
// assumes one 200 MHz clock and a 32-bit APB slave port holding the command registers
//
// How it works
// - reset and power lines float except while a pulse is being driven
// - confirm held 4 s, host on, keypad reset on: reset pulse of 1 s
// - after a keypad reset pulse, writes are refused until the block restarts
// - confirm held 0.25 s, host off: power pulse of set length, then restart
// - cancel held 4 s, host on, keypad power-off on: power pulse of set length
// - cancel still held at pulse end: keep driving up to 5 s more
// - blank option on and host off: display blanked and backlight off
// - sense source: internal 5 V sense when select is 1, gpio 1 when 0
// - rising host sense restarts sequencer, watchdog, key timers and acknowledge; config keeps its value
// - mask bits 0x10/0x20/0x40/0x80 enable blank, reset, power-on, power-off
// - mask bit 0x01 picks pulse polarity from the idle line level
// - mask bits 0x02/0x04 make reset/power pulses drive high while mask bit 0x01 is clear
// - pulse length in 1/32 s steps, 1 to 255, zero means 1 s
// - config takes one to three byte lanes and acknowledges with code 0x5c
// - watchdog timeout zero disarms, stopping a running countdown
// - watchdog expiry gives a reset pulse with the configured polarity
// - watchdog off at power-up and after it fires, until rearmed
// - readback: mask in byte 7, watchdog count byte 8, sense select byte 11

package atx_pkg;

    // time base: one tick every 1/32 s
    localparam int CLK_MHZ         = 200;
    localparam int TICK_US         = 31250;
    localparam int TICK_CYCLES_DEF = CLK_MHZ * TICK_US;

    localparam int HOLD_LONG_MS  = 4000;
    localparam int HOLD_SHORT_MS = 250;
    localparam int PULSE_DEF_MS  = 1000;
    localparam int EXTEND_MS     = 5000;
    localparam int WD_SECOND_MS  = 1000;

    localparam logic [8:0] HOLD_LONG_TICKS  = 9'(HOLD_LONG_MS * 1000 / TICK_US);
    localparam logic [8:0] HOLD_SHORT_TICKS = 9'(HOLD_SHORT_MS * 1000 / TICK_US);
    localparam logic [8:0] PULSE_DEF_TICKS  = 9'(PULSE_DEF_MS * 1000 / TICK_US);
    localparam logic [8:0] EXTEND_TICKS     = 9'(EXTEND_MS * 1000 / TICK_US);
    localparam logic [5:0] WD_SECOND_TICKS  = 6'(WD_SECOND_MS * 1000 / TICK_US);

    // register byte addresses
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_WDOG   = 8'h04;
    localparam logic [7:0] ADDR_STATE  = 8'h08;
    localparam logic [7:0] ADDR_ACK    = 8'h0c;
    localparam logic [7:0] ADDR_RB0    = 8'h10;
    localparam logic [7:0] ADDR_RB1    = 8'h14;
    localparam logic [7:0] ADDR_RB2    = 8'h18;
    localparam logic [7:0] ADDR_RB3    = 8'h1c;

    // function mask bit positions
    localparam int MASK_AUTO_POL  = 0;
    localparam int MASK_RST_INV   = 1;
    localparam int MASK_PWR_INV   = 2;
    localparam int MASK_BLANK     = 4;
    localparam int MASK_KEY_RST   = 5;
    localparam int MASK_KEY_PWRON = 6;
    localparam int MASK_KEY_PWROF = 7;

    // acknowledge type codes
    localparam logic [7:0] ACK_CONFIG = 8'h5c;
    localparam logic [7:0] ACK_WDOG   = 8'h5d;
    localparam logic [7:0] ACK_READ   = 8'h5e;

    typedef struct packed {
        logic       sense_internal;
        logic [7:0] pulse_len;
        logic [7:0] mask;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{sense_internal: 1'b1, pulse_len: 8'h00, mask: 8'h00};

    typedef struct packed {
        logic out;
        logic oe;
    } line_drv_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST_PULSE,
        ST_PWR_PULSE,
        ST_PWR_EXTEND,
        ST_RESTART
    } seq_state_t;

    typedef enum logic [1:0] {
        SRC_KEY_RST,
        SRC_WDOG,
        SRC_KEY_ON,
        SRC_KEY_OFF
    } pulse_src_t;

endpackage

// File: sim/atx_checker.sv
// port-level checker for the power and reset sequencer
// assumes it is bound onto atx_power_reset with the same tick parameter
`timescale 1ns/100ps
`default_nettype none

module atx_checker
    import atx_pkg::*;
#(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic      ref_clk,
    input wire logic      rst,
    // apb answer
    input wire logic      psel,
    input wire logic      penable,
    input wire logic      pready,
    input wire logic      pslverr,
    // sense and lines
    input wire logic      sense_5v,
    input wire logic      sense_gpio,
    input wire line_drv_t rst_drv,
    input wire line_drv_t pwr_drv,
    // display
    input wire logic      display_blank,
    input wire logic      backlight_off
);
    // one clock of slack either way, since the pulse starts off a tick boundary
    localparam int RST_LO = 32 * TICK_CYCLES - 1;
    localparam int RST_HI = 32 * TICK_CYCLES + 1;
    localparam int PWR_HI = 415 * TICK_CYCLES + 2;
    int rst_cnt;
    int pwr_cnt;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rst_cnt <= 0;
            pwr_cnt <= 0;
        end else begin
            rst_cnt <= rst_drv.oe ? rst_cnt + 1 : 0;
            pwr_cnt <= pwr_drv.oe ? pwr_cnt + 1 : 0;
        end
    end

    property p_ready_wait;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("apb answer late");
    property p_ready_once;
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready too long");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
    property p_one_line;
        !(rst_drv.oe && pwr_drv.oe);
    endproperty
    a_one_line: assert property (p_one_line) else $error("both lines driven");
    property p_rst_len;
        $fell(rst_drv.oe) |-> rst_cnt >= RST_LO && rst_cnt <= RST_HI;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
    property p_rst_out;
        rst_drv.oe && $past(rst_drv.oe) |-> $stable(rst_drv.out);
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset level moved");
    property p_pwr_out;
        $past(pwr_drv.oe, 1) && pwr_drv.oe |-> pwr_drv.out == $past(pwr_drv.out);
    endproperty
    a_pwr_out: assert property (p_pwr_out) else $error("power level moved");
    property p_pwr_max;
        pwr_drv.oe |-> pwr_cnt < PWR_HI;
    endproperty
    a_pwr_max: assert property (p_pwr_max) else $error("power pulse too long");
    property p_blank_pair;
        display_blank == backlight_off;
    endproperty
    a_blank_pair: assert property (p_blank_pair) else $error("blank mismatch");
    property p_blank_cause;
        $rose(display_blank) |-> !($past(sense_5v) && $past(sense_gpio));
    endproperty
    a_blank_cause: assert property (p_blank_cause) else $error("blank with host on");
endmodule

bind atx_power_reset atx_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .sense_5v(sense_5v), .sense_gpio(sense_gpio), .rst_drv(rst_drv),
    .pwr_drv(pwr_drv), .display_blank(display_blank), .backlight_off(backlight_off)
);

`default_nettype wire

// File: sim/host_board.sv
// board side of the reset and power lines, with host power state
// assumes pull-ups on both lines; host starts powered off
`timescale 1ns/100ps
`default_nettype none

module host_board
    import atx_pkg::*;
(
    // clock
    input  wire logic      ref_clk,
    // drive from the sequencer
    input  wire line_drv_t rst_drv,
    input  wire line_drv_t pwr_drv,
    // resolved lines and host state
    output logic           rst_line,
    output logic           pwr_line,
    output logic           host_on,
    output logic [7:0]     resets_seen,
    output logic [15:0]    pwr_len
);
    logic [15:0] len_r;
    logic        rst_low_r;

    assign rst_line = rst_drv.oe ? rst_drv.out : 1'b1;
    assign pwr_line = pwr_drv.oe ? pwr_drv.out : 1'b1;

    initial begin
        {host_on, resets_seen, pwr_len, len_r, rst_low_r} = '0;
    end

    // host toggles power when a low press ends
    always @(posedge ref_clk) begin
        rst_low_r <= !rst_line;
        if (!rst_line && !rst_low_r) begin
            resets_seen <= resets_seen + 8'h01;
        end
        if (!pwr_line) begin
            len_r <= len_r + 16'h0001;
        end else if (len_r != 16'h0000) begin
            host_on <= !host_on;
            pwr_len <= len_r;
            len_r   <= 16'h0000;
        end
    end
endmodule

`default_nettype wire

// File: sim/tb_atx_host_power_reset_watchdog.sv
// self-checking bench for the power and reset sequencer over apb
// assumes a four-clock tick, so one second is 128 clocks
`timescale 1ns/100ps
`default_nettype none

module tb_atx_host_power_reset_watchdog
    import atx_pkg::*;
;
    localparam int TICK = 4;
    logic        ref_clk, rst, psel, penable, pwrite;
    logic        confirm_key, cancel_key, sense_gpio;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr, display_blank, backlight_off;
    logic        rst_line, pwr_line, host_on;
    line_drv_t   rst_drv, pwr_drv;
    logic [7:0]  resets_seen;
    logic [15:0] pwr_len;
    int          error_cnt = 0;
    int          n_tests = 0;

    atx_power_reset #(.TICK_CYCLES(TICK)) dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .confirm_key(confirm_key), .cancel_key(cancel_key),
        .sense_5v(host_on), .sense_gpio(sense_gpio), .rst_line_in(rst_line),
        .rst_drv(rst_drv), .pwr_line_in(pwr_line), .pwr_drv(pwr_drv),
        .display_blank(display_blank), .backlight_off(backlight_off)
    );
    host_board board (
        .ref_clk(ref_clk), .rst_drv(rst_drv), .pwr_drv(pwr_drv), .rst_line(rst_line),
        .pwr_line(pwr_line), .host_on(host_on), .resets_seen(resets_seen), .pwr_len(pwr_len)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // read data is compared only when no refusal is expected
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [31:0] exp, input logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        check({31'h0, pslverr}, {31'h0, err});
        if (!wr && !err) begin
            check(prdata, exp);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // sel 0 reset enable, 1 power enable, 2 host state
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        logic v;
        int   n;
        n = 0;
        do begin
            @(posedge ref_clk);
            v = sel == 0 ? rst_drv.oe : sel == 1 ? pwr_drv.oe : host_on;
            n++;
        end while (v !== lvl && n < lim);
        check({31'h0, v}, {31'h0, lvl});
    endtask

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, confirm_key, cancel_key, sense_gpio} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        idle(5);
        rst <= 1'b0;
        idle(1);
        confirm_key <= 1'b1;
        idle(80);
        check({30'h0, rst_drv.oe, pwr_drv.oe}, 32'h0);
        confirm_key <= 1'b0;
        xfer(1'b1, ADDR_CONFIG, 32'h0001_10f0, 4'h7, 32'h0, 1'b0);
        xfer(1'b0, ADDR_ACK, 32'h0, 4'hf, 32'h0000_015c, 1'b0);
        xfer(1'b1, ADDR_CONFIG, 32'h00ff_ccf0, 4'h1, 32'h0, 1'b0);
        xfer(1'b0, ADDR_CONFIG, 32'h0, 4'hf, 32'h0001_10f0, 1'b0);
        xfer(1'b0, ADDR_RB1, 32'h0, 4'hf, 32'hf000_0000, 1'b0);
        xfer(1'b0, ADDR_ACK, 32'h0, 4'hf, 32'h0000_015e, 1'b0);
        xfer(1'b1, ADDR_STATE, 32'h1, 4'hf, 32'h0, 1'b1);
        xfer(1'b0, 8'h40, 32'h0, 4'hf, 32'h0, 1'b1);
        check({31'h0, display_blank}, 32'h1);
        confirm_key <= 1'b1;
        wait_for(1, 1'b1, 200);
        check({31'h0, pwr_drv.out}, 32'h0);
        confirm_key <= 1'b0;
        wait_for(2, 1'b1, 200);
        check({16'h0, pwr_len}, 32'(16 * TICK));
        idle(10);
        check({31'h0, display_blank}, 32'h0);
        xfer(1'b1, ADDR_WDOG, 32'h2, 4'h1, 32'h0, 1'b0);
        xfer(1'b0, ADDR_WDOG, 32'h0, 4'hf, 32'h0000_0102, 1'b0);
        xfer(1'b0, ADDR_RB2, 32'h0, 4'hf, 32'h0100_0002, 1'b0);
        repeat (3) begin
            idle(150);
            xfer(1'b1, ADDR_WDOG, 32'h2, 4'h1, 32'h0, 1'b0);
        end
        xfer(1'b1, ADDR_WDOG, 32'h0, 4'h1, 32'h0, 1'b0);
        xfer(1'b0, ADDR_WDOG, 32'h0, 4'hf, 32'h0, 1'b0);
        idle(400);
        check({24'h0, resets_seen}, 32'h0);
        xfer(1'b1, ADDR_WDOG, 32'h1, 4'h1, 32'h0, 1'b0);
        wait_for(0, 1'b1, 300);
        check({31'h0, rst_drv.out}, 32'h0);
        wait_for(0, 1'b0, 200);
        xfer(1'b0, ADDR_WDOG, 32'h0, 4'hf, 32'h0, 1'b0);
        idle(400);
        check({24'h0, resets_seen}, 32'h1);
        xfer(1'b1, ADDR_CONFIG, 32'h0000_00f2, 4'h1, 32'h0, 1'b0);
        confirm_key <= 1'b1;
        idle(400);
        confirm_key <= 1'b0;
        check({31'h0, rst_drv.oe}, 32'h0);
        idle(2);
        confirm_key <= 1'b1;
        idle(480);
        check({31'h0, rst_drv.oe}, 32'h0);
        wait_for(0, 1'b1, 100);
        check({31'h0, rst_drv.out}, 32'h1);
        confirm_key <= 1'b0;
        wait_for(0, 1'b0, 200);
        // lockout lasts until the next tick, so this write lands inside it
        xfer(1'b1, ADDR_CONFIG, 32'h0000_00f0, 4'h1, 32'h0, 1'b1);
        idle(20);
        xfer(1'b0, ADDR_CONFIG, 32'h0, 4'hf, 32'h0001_10f2, 1'b0);
        xfer(1'b1, ADDR_CONFIG, 32'h0000_00f5, 4'h1, 32'h0, 1'b0);
        cancel_key <= 1'b1;
        wait_for(1, 1'b1, 600);
        check({31'h0, pwr_drv.out}, 32'h0);
        idle(150);
        check({31'h0, pwr_drv.oe}, 32'h1);
        cancel_key <= 1'b0;
        wait_for(1, 1'b0, 10);
        wait_for(2, 1'b0, 20);
        idle(10);
        check({31'h0, display_blank}, 32'h1);
        xfer(1'b1, ADDR_CONFIG, 32'h0000_00f0, 4'h5, 32'h0, 1'b0);
        xfer(1'b1, ADDR_WDOG, 32'h5, 4'h1, 32'h0, 1'b0);
        sense_gpio <= 1'b1;
        idle(10);
        check({31'h0, display_blank}, 32'h0);
        xfer(1'b0, ADDR_STATE, 32'h0, 4'hf, 32'h0000_0040, 1'b0);
        xfer(1'b0, ADDR_RB2, 32'h0, 4'hf, 32'h0, 1'b0);
        close_out();
    end

    // the scenarios need under 6000 clocks
    initial begin
        idle(20000);
        error_cnt++;
        close_out();
    end
endmodule

`default_nettype wire
